// *** include/gpcde_pkg.sv ***
package gpcde_pkg;
  // ---------------------------------------------------------------
  // register word addresses (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_D_DATA_LATCH_ADDR = 8'h0C; // index 0x0003
  localparam logic [7:0] PORT_E_DATA_LATCH_ADDR = 8'h20; // index 0x0008
  localparam logic [7:0] PORT_C_PULLUP_ENABLES_ADDR = 8'h40;
  localparam logic [7:0] PORT_D_DIRECTION_ADDR = 8'h44;
  localparam logic [7:0] PORT_D_PULLUP_ENABLES_ADDR = 8'h48;
  localparam logic [7:0] PORT_E_DIRECTION_ADDR = 8'h4C;
  localparam logic [7:0] PORT_C_DIRECTION_ADDR = 8'h50;
  localparam logic [7:0] PERIPH_CTRL_ADDR = 8'h54;
  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int PORT_C_WIDTH = 7;
  localparam int PORT_D_WIDTH = 8;
  localparam int PORT_E_WIDTH = 5;
  localparam int SPI_PIN_COUNT = 4;
  localparam int SS_BIT = 0;
  localparam int TIMER_PIN_LO = 6;
  localparam int TIMER_PIN_HI = 7;
  localparam int TXD_BIT = 0;
  localparam int RXD_BIT = 1;
  localparam int OSC_OUT_BIT = 3;
  localparam int OSC_IN_BIT = 4;
  // control register fields
  localparam int CTL_SPI_EN = 0;
  localparam int CTL_SPI_MSTR = 1;
  localparam int CTL_SCI_EN = 2;
  localparam int CTL_OSC_EN = 3;
  localparam int CTL_WIDTH = 4;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] PUE_RESET = 8'h00;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 4'h0;
endpackage

// *** core/gpcde_ports.sv ***
// What this block does
// - first-port pins each own a pullup bit
// - first-port output direction kills its pullup
// - pullup bit 1 connects, 0 disconnects
// - second port: eight latches, reset leaves them
// - timer select bits claim top two pins
// - spi off frees low four pins
// - master mode frees the slave-select pin
// - spi pins: direction only picks read source and pullup
// - second-port direction resets 0; 1 drives
// - second-port read: latch if output, else pin
// - latch writes always land, inputs unaffected
// - second-port pullup bits, hi-z or output modes
// - second-port output direction kills its pullup
// - third port: five latches, reset leaves them
// - oscillator pins ignore writes, read the pin level
// - serial off frees receive and transmit pins
// - serial pins: direction only picks read source
// - third-port direction resets 0; 1 drives
// - third-port read: latch if output, else pin
`timescale 1ns/100ps
`default_nettype none
module gpcde_ports (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // first port pads
  input wire logic [gpcde_pkg::PORT_C_WIDTH-1:0] port_c_pin_in,
  output logic [gpcde_pkg::PORT_C_WIDTH-1:0] port_c_pin_out,
  output logic [gpcde_pkg::PORT_C_WIDTH-1:0] port_c_pin_oe,
  output logic [gpcde_pkg::PORT_C_WIDTH-1:0] port_c_pullup_on,
  // second port pads
  input wire logic [gpcde_pkg::PORT_D_WIDTH-1:0] port_d_pin_in,
  output logic [gpcde_pkg::PORT_D_WIDTH-1:0] port_d_pin_out,
  output logic [gpcde_pkg::PORT_D_WIDTH-1:0] port_d_pin_oe,
  output logic [gpcde_pkg::PORT_D_WIDTH-1:0] port_d_pullup_on,
  // third port pads
  input wire logic [gpcde_pkg::PORT_E_WIDTH-1:0] port_e_pin_in,
  output logic [gpcde_pkg::PORT_E_WIDTH-1:0] port_e_pin_out,
  output logic [gpcde_pkg::PORT_E_WIDTH-1:0] port_e_pin_oe,
  // spi peripheral (low four pins of the second port)
  input wire logic [gpcde_pkg::SPI_PIN_COUNT-1:0] spi_pad_out,
  input wire logic [gpcde_pkg::SPI_PIN_COUNT-1:0] spi_pad_oe,
  // timer channels on the top two pins of the second port
  input wire logic [1:0] timer_edge_level_sel_hi,
  input wire logic [1:0] timer_edge_level_sel_lo,
  input wire logic [1:0] timer_ch_out,
  input wire logic [1:0] timer_ch_oe,
  // serial interface on the two low pins of the third port
  input wire logic [1:0] sci_pad_out,
  input wire logic [1:0] sci_pad_oe
);
  import gpcde_pkg::*;

  localparam int CW = PORT_C_WIDTH;
  localparam int DW = PORT_D_WIDTH;
  localparam int EW = PORT_E_WIDTH;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [DW-1:0] second_port_latch_q;
  logic [EW-1:0] third_port_latch_q;
  logic [CW-1:0] first_port_latch_q;
  logic [CW-1:0] first_port_direction_bits_q;
  logic [CW-1:0] first_port_pullup_bits_q;
  logic [DW-1:0] second_port_direction_bits_q;
  logic [DW-1:0] second_port_pullup_bits_q;
  logic [EW-1:0] third_port_direction_bits_q;
  logic [CTL_WIDTH-1:0] ctl_q;
  logic read_pending_q;

  // ---------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2nd and 3rd agree
  // ---------------------------------------------------------------
  localparam int PW = CW + DW + EW;
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic [PW-1:0] pin_s3_q;
  logic [PW-1:0] pin_stable_q;

  // reset is synchronous and only clears to constants
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {port_e_pin_in, port_d_pin_in, port_c_pin_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // per-bit agreement filter rejects a single-cycle disagreement;
  // the price is latency: a pin change reaches a read four edges on,
  // so software polling a pin must allow for that delay
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_stable_q <= '0;
    end else begin
      for (int i = 0; i < PW; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_stable_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  logic [CW-1:0] c_pin;
  logic [DW-1:0] d_pin;
  logic [EW-1:0] e_pin;
  assign c_pin = pin_stable_q[CW-1:0];
  assign d_pin = pin_stable_q[CW+DW-1:CW];
  assign e_pin = pin_stable_q[PW-1:CW+DW];

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_lo;
  assign wr_lo = avs_write && avs_byteenable[0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // oscillator pins, decoded in the write and the pad paths
  function automatic logic osc_pin(input int idx);
    osc_pin = (idx == OSC_IN_BIT) || (idx == OSC_OUT_BIT);
  endfunction

  // ---------------------------------------------------------------
  // peripheral ownership
  // ---------------------------------------------------------------
  logic [DW-1:0] d_owned;
  logic [EW-1:0] e_owned;
  logic osc_mode;
  assign osc_mode = ctl_q[CTL_OSC_EN];

  // spi takes low pins only when enabled; ss freed again in master mode
  always_comb begin
    d_owned = '0;
    for (int i = 0; i < SPI_PIN_COUNT; i++) begin
      d_owned[i] = ctl_q[CTL_SPI_EN];
    end
    if (ctl_q[CTL_SPI_MSTR]) begin
      d_owned[SS_BIT] = 1'b0;
    end
    // any nonzero edge/level select hands the pin to the timer
    // a capture-only mode claims the pin too; the timer then holds oe low
    d_owned[TIMER_PIN_LO] = timer_edge_level_sel_hi[0] | timer_edge_level_sel_lo[0];
    d_owned[TIMER_PIN_HI] = timer_edge_level_sel_hi[1] | timer_edge_level_sel_lo[1];
  end

  // serial pins owned only while the serial interface is enabled
  always_comb begin
    e_owned = '0;
    e_owned[TXD_BIT] = ctl_q[CTL_SCI_EN];
    e_owned[RXD_BIT] = ctl_q[CTL_SCI_EN];
  end

  // ---------------------------------------------------------------
  // latch writes: second and third port latches have no reset, written whatever the direction, except third-port oscillator pins in clock mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_lo && hit(avs_address, PORT_D_DATA_LATCH_ADDR)) begin
      second_port_latch_q <= avs_writedata[DW-1:0];
    end
  end

  // oscillator pins swallow writes while in clock mode
  always_ff @(posedge clk) begin
    if (wr_lo && hit(avs_address, PORT_E_DATA_LATCH_ADDR)) begin
      for (int i = 0; i < EW; i++) begin
        if (!(osc_mode && osc_pin(i))) begin
          third_port_latch_q[i] <= avs_writedata[i];
        end
      end
    end
  end

  // first port latch, kept local so the pad has a defined drive value
  // it shares the first-port direction word, byte lane 1 (bits 14:8), since
  // the first port has no data address of its own here
  always_ff @(posedge clk) begin
    if (srst) begin
      first_port_latch_q <= '0;
    end else if (wr_lo && hit(avs_address, PORT_C_DIRECTION_ADDR) && avs_byteenable[1]) begin
      first_port_latch_q <= avs_writedata[CW+7:8];
    end
  end

  // ---------------------------------------------------------------
  // direction, pullup and control registers
  // ---------------------------------------------------------------
  // direction bits: cleared by reset, so every pad starts as an input
  always_ff @(posedge clk) begin
    if (srst) begin
      second_port_direction_bits_q <= DIR_RESET[DW-1:0];
      third_port_direction_bits_q <= DIR_RESET[EW-1:0];
      first_port_direction_bits_q <= DIR_RESET[CW-1:0];
    end else if (wr_lo) begin
      if (hit(avs_address, PORT_D_DIRECTION_ADDR)) second_port_direction_bits_q <= avs_writedata[DW-1:0];
      if (hit(avs_address, PORT_E_DIRECTION_ADDR)) third_port_direction_bits_q <= avs_writedata[EW-1:0];
      if (hit(avs_address, PORT_C_DIRECTION_ADDR)) first_port_direction_bits_q <= avs_writedata[CW-1:0];
    end
  end

  // pullup bits: stored as written, masked by direction at the pad
  always_ff @(posedge clk) begin
    if (srst) begin
      first_port_pullup_bits_q <= PUE_RESET[CW-1:0];
      second_port_pullup_bits_q <= PUE_RESET[DW-1:0];
    end else if (wr_lo) begin
      if (hit(avs_address, PORT_C_PULLUP_ENABLES_ADDR)) first_port_pullup_bits_q <= avs_writedata[CW-1:0];
      if (hit(avs_address, PORT_D_PULLUP_ENABLES_ADDR)) second_port_pullup_bits_q <= avs_writedata[DW-1:0];
    end
  end

  // peripheral enables, standing in for the owning blocks' own bits
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= CTL_RESET;
    end else if (wr_lo && hit(avs_address, PERIPH_CTRL_ADDR)) begin
      ctl_q <= avs_writedata[CTL_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // read path: direction picks latch or pin, even for owned pins; oscillator pins in clock mode read the pin
  // ---------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    unique case (avs_address)
      PORT_D_DATA_LATCH_ADDR: begin
        for (int i = 0; i < DW; i++) begin
          rd_d[i] = second_port_direction_bits_q[i] ? second_port_latch_q[i] : d_pin[i];
        end
      end
      PORT_E_DATA_LATCH_ADDR: begin
        for (int i = 0; i < EW; i++) begin
          rd_d[i] = third_port_direction_bits_q[i] ? third_port_latch_q[i] : e_pin[i];
        end
        // oscillator pins read as undefined; return pin level as-is
        // giving the pin keeps the read free of unknowns in simulation
        if (osc_mode) begin
          rd_d[OSC_IN_BIT] = e_pin[OSC_IN_BIT];
          rd_d[OSC_OUT_BIT] = e_pin[OSC_OUT_BIT];
        end
      end
      PORT_C_PULLUP_ENABLES_ADDR: rd_d[CW-1:0] = first_port_pullup_bits_q;
      PORT_D_DIRECTION_ADDR: rd_d[DW-1:0] = second_port_direction_bits_q;
      PORT_D_PULLUP_ENABLES_ADDR: rd_d[DW-1:0] = second_port_pullup_bits_q;
      PORT_E_DIRECTION_ADDR: rd_d[EW-1:0] = third_port_direction_bits_q;
      PORT_C_DIRECTION_ADDR: begin
        rd_d[CW-1:0] = first_port_direction_bits_q;
        for (int i = 0; i < CW; i++) begin
          rd_d[8+i] = first_port_direction_bits_q[i] ? first_port_latch_q[i] : c_pin[i];
        end
      end
      PERIPH_CTRL_ADDR: rd_d[CTL_WIDTH-1:0] = ctl_q;
      default: rd_d = '0; // unmapped reads give zero
    endcase
  end

  // one wait cycle on reads so readdata comes from a flop; writes take at once
  always_ff @(posedge clk) begin
    if (srst) begin
      read_pending_q <= 1'b0;
      avs_readdata <= '0;
    end else begin
      read_pending_q <= avs_read && !read_pending_q;
      if (avs_read && !read_pending_q) avs_readdata <= rd_d;
    end
  end

  // waitrequest high only in the first cycle of a read; it is the one
  // output not taken from a flop, since a registered stall would cost
  // every write a wait cycle as well
  assign avs_waitrequest = avs_read && !read_pending_q;

  // ---------------------------------------------------------------
  // pad drive, registered so every output comes from a flop
  // ---------------------------------------------------------------
  // the first port has no peripheral, so latch and direction go straight out
  always_ff @(posedge clk) begin
    if (srst) begin
      port_c_pin_out <= '0;
      port_c_pin_oe <= '0;
      port_c_pullup_on <= '0;
    end else begin
      port_c_pin_out <= first_port_latch_q;
      port_c_pin_oe <= first_port_direction_bits_q;
      port_c_pullup_on <= first_port_pullup_bits_q & ~first_port_direction_bits_q;
    end
  end

  // ---------------------------------------------------------------
  // peripheral drive gathered per pin of the second port
  // ---------------------------------------------------------------
  // pins that no peripheral can own carry zero here; the owner mask
  // never picks them, so these zeros never reach a pad
  logic [DW-1:0] d_per_out;
  logic [DW-1:0] d_per_oe;
  always_comb begin
    d_per_out = '0;
    d_per_oe = '0;
    d_per_out[SPI_PIN_COUNT-1:0] = spi_pad_out;
    d_per_oe[SPI_PIN_COUNT-1:0] = spi_pad_oe;
    d_per_out[TIMER_PIN_HI:TIMER_PIN_LO] = timer_ch_out;
    d_per_oe[TIMER_PIN_HI:TIMER_PIN_LO] = timer_ch_oe;
  end

  // peripheral value and enable replace latch and direction when owned;
  // the pullup still follows direction, so an owned pin keeps its pullup
  // while its direction bit is 0, whatever the peripheral drives
  always_ff @(posedge clk) begin
    if (srst) begin
      port_d_pin_out <= '0;
      port_d_pin_oe <= '0;
      port_d_pullup_on <= '0;
    end else begin
      port_d_pin_out <= (d_owned & d_per_out) | (~d_owned & second_port_latch_q);
      port_d_pin_oe <= (d_owned & d_per_oe) | (~d_owned & second_port_direction_bits_q);
      port_d_pullup_on <= second_port_pullup_bits_q & ~second_port_direction_bits_q;
    end
  end

  // serial drive gathered per pin of the third port
  logic [EW-1:0] e_per_out;
  logic [EW-1:0] e_per_oe;
  always_comb begin
    e_per_out = '0;
    e_per_oe = '0;
    e_per_out[TXD_BIT] = sci_pad_out[TXD_BIT];
    e_per_out[RXD_BIT] = sci_pad_out[RXD_BIT];
    e_per_oe[TXD_BIT] = sci_pad_oe[TXD_BIT];
    e_per_oe[RXD_BIT] = sci_pad_oe[RXD_BIT];
  end

  // oscillator pins are released to the clock generator (oe low)
  always_ff @(posedge clk) begin
    if (srst) begin
      port_e_pin_out <= '0;
      port_e_pin_oe <= '0;
    end else begin
      for (int i = 0; i < EW; i++) begin
        if (e_owned[i]) begin
          port_e_pin_out[i] <= e_per_out[i];
          port_e_pin_oe[i] <= e_per_oe[i];
        end else if (osc_mode && osc_pin(i)) begin
          port_e_pin_out[i] <= 1'b0;
          port_e_pin_oe[i] <= 1'b0;
        end else begin
          port_e_pin_out[i] <= third_port_latch_q[i];
          port_e_pin_oe[i] <= third_port_direction_bits_q[i];
        end
      end
    end
  end

endmodule // gpcde_ports
`default_nettype wire

// *** tb/gpcde_ports_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// checker on the bus, pad and timer ports
// ------------------------------------------------
module gpcde_ports_chk
  import gpcde_pkg::*;
(
  // clock, reset and bus
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // pads and timer
  input wire logic [6:0] port_c_pin_oe,
  input wire logic [6:0] port_c_pullup_on,
  input wire logic [7:0] port_d_pin_out,
  input wire logic [7:0] port_d_pin_oe,
  input wire logic [7:0] port_d_pullup_on,
  input wire logic [4:0] port_e_pin_out,
  input wire logic [4:0] port_e_pin_oe,
  input wire logic [1:0] timer_edge_level_sel_hi,
  input wire logic [1:0] timer_edge_level_sel_lo,
  input wire logic [1:0] timer_ch_out,
  input wire logic [1:0] timer_ch_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // lane-0 write strobes; pads follow two edges later, so checks wait ##2
  wire logic wr_0 = avs_write && avs_byteenable[0];
  wire logic [1:0] tsel = timer_edge_level_sel_hi | timer_edge_level_sel_lo;
  property p_wr_nowait; wr_0 |-> !avs_waitrequest; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_ans; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read wait too long");
  property p_rst; $fell(srst) |-> !(|{port_c_pin_oe, port_d_pin_oe, port_e_pin_oe, port_d_pullup_on}); endproperty
  a_rst: assert property (p_rst) else $error("pads not inputs after reset");
  property p_c_excl; (port_c_pullup_on & port_c_pin_oe) == 7'h00; endproperty
  a_c_excl: assert property (p_c_excl) else $error("pullup on an output");
  property p_c_pu; wr_0 && avs_address == PORT_C_PULLUP_ENABLES_ADDR |->
    ##2 port_c_pullup_on == ($past(avs_writedata[6:0], 2) & ~port_c_pin_oe); endproperty
  a_c_pu: assert property (p_c_pu) else $error("pullup bits not applied");
  property p_d_pu; wr_0 && avs_address == PORT_D_DIRECTION_ADDR |->
    ##2 (port_d_pullup_on & $past(avs_writedata[7:0], 2)) == 8'h00; endproperty
  a_d_pu: assert property (p_d_pu) else $error("pullup left on an output");
  property p_t6; $past(tsel[0]) |-> {port_d_pin_oe[6], port_d_pin_out[6]} == $past({timer_ch_oe[0], timer_ch_out[0]});
  endproperty
  a_t6: assert property (p_t6) else $error("timer pin 6 not routed");
  property p_t7; $past(tsel[1]) |-> {port_d_pin_oe[7], port_d_pin_out[7]} == $past({timer_ch_oe[1], timer_ch_out[1]});
  endproperty
  a_t7: assert property (p_t7) else $error("timer pin 7 not routed");
  property p_d_lat; wr_0 && avs_address == PORT_D_DATA_LATCH_ADDR |->
    ##2 (port_d_pin_oe[5:4] & (port_d_pin_out[5:4] ^ $past(avs_writedata[5:4], 2))) == 2'h0; endproperty
  a_d_lat: assert property (p_d_lat) else $error("latch not on pad");
  property p_e_lat; wr_0 && avs_address == PORT_E_DATA_LATCH_ADDR |->
    ##2 !(port_e_pin_oe[2] && (port_e_pin_out[2] != $past(avs_writedata[2], 2))); endproperty
  a_e_lat: assert property (p_e_lat) else $error("latch not on pad");
endmodule // gpcde_ports_chk
bind gpcde_ports gpcde_ports_chk chk_u (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .port_c_pin_oe, .port_c_pullup_on, .port_d_pin_out, .port_d_pin_oe,
  .port_d_pullup_on, .port_e_pin_out, .port_e_pin_oe, .timer_edge_level_sel_hi, .timer_edge_level_sel_lo,
  .timer_ch_out, .timer_ch_oe);
`default_nettype wire

// *** tb/gpcde_pads.sv ***
`timescale 1ns/100ps
`default_nettype none
// board pads: driven, pulled up, or floating
module gpcde_pads #(parameter int W = 8) (
  // design side
  input wire logic clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu,
  // board side
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin
);
  logic [W-1:0] flt_q = '0;
  // a floating line wanders so a stale level never passes for a real one
  always_ff @(posedge clk) begin
    flt_q <= ~flt_q;
  end
  assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | flt_q));
endmodule // gpcde_pads
`default_nettype wire

// *** tb/tb_gpcde_ports.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t: %h", $time, a); end end
module tb_gpcde_ports;
  import gpcde_pkg::*;
  // ------------------------------------------------
  // stimulus, pads and design
  // ------------------------------------------------
  logic clk = 0, srst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00, ld, dd, xv_d = 8'h00, xe_d = 8'hFF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, r, exv, lf = 32'h011BADE9;
  logic [3:0] avs_byteenable = 4'hF, spi_pad_out = 4'h0, spi_pad_oe = 4'h0;
  logic [1:0] timer_edge_level_sel_hi = 2'h0, timer_edge_level_sel_lo = 2'h0, timer_ch_out = 2'h0, timer_ch_oe = 2'h0;
  logic [1:0] sci_pad_out = 2'h0, sci_pad_oe = 2'h0;
  logic [6:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_c_pullup_on, xe_c = 7'h7F;
  logic [7:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe, port_d_pullup_on;
  logic [4:0] port_e_pin_in, port_e_pin_out, port_e_pin_oe, xv_e = 5'h00;
  logic [31:0] exq[$];
  int n_fail = 0, n_tests = 0;
  gpcde_ports dut_u (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe, .port_c_pullup_on,
    .port_d_pin_in, .port_d_pin_out, .port_d_pin_oe, .port_d_pullup_on, .port_e_pin_in, .port_e_pin_out,
    .port_e_pin_oe, .spi_pad_out, .spi_pad_oe, .timer_edge_level_sel_hi, .timer_edge_level_sel_lo,
    .timer_ch_out, .timer_ch_oe, .sci_pad_out, .sci_pad_oe);
  gpcde_pads #(.W(7)) pad_c (.clk, .out(port_c_pin_out), .oe(port_c_pin_oe), .pu(port_c_pullup_on),
    .ext_val(xv_d[6:0]), .ext_en(xe_c), .pin(port_c_pin_in));
  gpcde_pads #(.W(8)) pad_d (.clk, .out(port_d_pin_out), .oe(port_d_pin_oe), .pu(port_d_pullup_on),
    .ext_val(xv_d), .ext_en(xe_d), .pin(port_d_pin_in));
  gpcde_pads #(.W(5)) pad_e (.clk, .out(port_e_pin_out), .oe(port_e_pin_oe), .pu(5'h00),
    .ext_val(xv_e), .ext_en(5'h1F), .pin(port_e_pin_in));
  initial begin
    forever #4 clk = ~clk;
  end
  // closing report, also reached by an exhausted wait
  task automatic wrap_up();
    $display("tests %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  // one bus access; a read leaves its expected word in the queue
  task automatic acc(input int w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    int i;
    if (w == 0) exq.push_back(e);
    @(posedge clk);
    avs_write <= (w != 0);
    avs_read <= (w == 0);
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (!avs_waitrequest) break;
    end
    if (i == 20) n_fail++;
    if (i == 20) wrap_up();
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // read words checked against the oldest note
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      exv = exq.pop_front();
      `CHK(avs_readdata, exv)
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    acc(0, PORT_D_DIRECTION_ADDR, 0, 32'h0);
    acc(0, PORT_E_DIRECTION_ADDR, 0, 32'h0);
    acc(0, PORT_D_PULLUP_ENABLES_ADDR, 0, 32'h0);
    acc(0, PORT_C_PULLUP_ENABLES_ADDR, 0, 32'h0);
    acc(0, PERIPH_CTRL_ADDR, 0, 32'h0);
    acc(0, 8'hFC, 0, 32'h0);
    $display("reset values done");
    // data ports: latch for outputs, pin for inputs; latch written first
    repeat (4) begin
      r = rnd();
      {dd, ld} = r[15:0];
      xv_d <= r[23:16];
      xv_e <= r[28:24];
      acc(1, PORT_D_DATA_LATCH_ADDR, {24'h0, ld}, 0);
      acc(1, PORT_D_DIRECTION_ADDR, {24'h0, dd}, 0);
      acc(1, PORT_E_DATA_LATCH_ADDR, {24'h0, ld}, 0);
      acc(1, PORT_E_DIRECTION_ADDR, {27'h0, dd[4:0]}, 0);
      repeat (6) @(posedge clk);
      acc(0, PORT_D_DATA_LATCH_ADDR, 0, {24'h0, ld & dd | xv_d & ~dd});
      acc(0, PORT_E_DATA_LATCH_ADDR, 0, {27'h0, ld[4:0] & dd[4:0] | xv_e & ~dd[4:0]});
    end
    $display("data ports done");
    // released pins with pullups read high; outputs read the latch
    xe_d <= 8'h00;
    xe_c <= 7'h00;
    acc(1, PORT_C_PULLUP_ENABLES_ADDR, 32'h7F, 0);
    acc(1, PORT_C_DIRECTION_ADDR, 32'h2A0F, 0);
    acc(1, PORT_D_PULLUP_ENABLES_ADDR, 32'hFF, 0);
    acc(1, PORT_D_DIRECTION_ADDR, 32'h0F, 0);
    repeat (8) @(posedge clk);
    acc(0, PORT_D_DATA_LATCH_ADDR, 0, {24'h0, ld & 8'h0F | 8'hF0});
    acc(0, PORT_C_DIRECTION_ADDR, 0, 32'h7A0F);
    `CHK({port_c_pullup_on, port_c_pin_oe, port_c_pin_out}, {7'h70, 7'h0F, 7'h2A})
    `CHK(port_d_pullup_on, 8'hF0)
    $display("pullups done");
    // spi takes the low pins, master mode frees slave select
    xe_d <= 8'hFF;
    r = rnd();
    spi_pad_out <= r[3:0];
    spi_pad_oe <= 4'hE;
    acc(1, PORT_D_DIRECTION_ADDR, 32'h00, 0);
    acc(1, PERIPH_CTRL_ADDR, 32'h1, 0);
    repeat (8) @(posedge clk);
    `CHK(port_d_pin_oe[3:0], 4'hE)
    `CHK(port_d_pin_out[3:1], spi_pad_out[3:1])
    acc(0, PORT_D_DATA_LATCH_ADDR, 0, {24'h0, xv_d[7:4], spi_pad_out[3:1], xv_d[0]});
    acc(1, PORT_D_DIRECTION_ADDR, 32'h0F, 0);
    acc(1, PERIPH_CTRL_ADDR, 32'h3, 0);
    spi_pad_oe <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK(port_d_pin_oe[3:0], 4'h1)
    acc(1, PERIPH_CTRL_ADDR, 32'h0, 0);
    repeat (3) @(posedge clk);
    `CHK(port_d_pin_oe[3:0], 4'hF)
    $display("spi done");
    // serial pins, then oscillator pins ignore latch writes
    sci_pad_oe <= 2'h3;
    sci_pad_out <= r[5:4];
    acc(1, PORT_E_DIRECTION_ADDR, 32'h00, 0);
    acc(1, PERIPH_CTRL_ADDR, 32'h4, 0);
    repeat (3) @(posedge clk);
    `CHK(port_e_pin_oe[1:0], 2'h3)
    `CHK(port_e_pin_out[1:0], sci_pad_out)
    acc(1, PORT_E_DATA_LATCH_ADDR, 32'h00, 0);
    acc(1, PERIPH_CTRL_ADDR, 32'h8, 0);
    acc(1, PORT_E_DATA_LATCH_ADDR, 32'h1F, 0);
    acc(1, PERIPH_CTRL_ADDR, 32'h0, 0);
    acc(1, PORT_E_DIRECTION_ADDR, 32'h1F, 0);
    acc(0, PORT_E_DATA_LATCH_ADDR, 0, 32'h07);
    $display("serial and oscillator done");
    // timer channels claim and release the top pins
    repeat (16) begin
      r = rnd();
      @(posedge clk);
      {timer_edge_level_sel_hi, timer_edge_level_sel_lo, timer_ch_out, timer_ch_oe} <= r[7:0];
    end
    repeat (3) @(posedge clk);
    $display("timer done");
    wrap_up();
  end
endmodule // tb_gpcde_ports
`default_nettype wire
